// file: hdl/ioac_decoder.sv
// i/o address condition decoder with apb status and interrupt
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ioac_defs.svh"
module ioac_decoder
  import ioac_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // instruction strobe from the sequencer
  input  wire logic        exec_in,
  input  wire logic [23:0] instr_in,
  input  wire logic [14:0] pc_in,
  output logic             done_out,
  output logic             skip_out,
  output logic [14:0]      next_pc_out,
  // unit status bus from peripherals (asynchronous)
  output logic [5:0]       unit_sel_out,
  input  wire logic [5:0]  unit_sig_in,
  // internal sources (asynchronous pins)
  input  wire logic        ybuf_ready_in,
  input  wire logic        wbuf_ready_in,
  input  wire logic        ybuf_err_in,
  input  wire logic        wbuf_err_in,
  input  wire logic [3:0]  bkpt_in,
  input  wire logic        ovf_set_in,
  output logic             int_enable_out,
  output logic             overflow_out,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 14;
  logic [SW-1:0] raw, s1_q, s2_q;
  assign raw = {unit_sig_in, ybuf_ready_in, wbuf_ready_in, ybuf_err_in,
                wbuf_err_in, bkpt_in};
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic [5:0] usig;
  logic       yrdy, wrdy, yerr, werr;
  logic [3:0] bkpt;
  assign {usig, yrdy, wrdy, yerr, werr, bkpt} = s2_q;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  ioac_cmd_t  cmd;
  logic       internal;
  logic [5:0] unit_code, sig_sel;
  ioac_field_dec u_dec (
    .instr_in     (instr_in),
    .cmd_out      (cmd),
    .internal_out (internal),
    .unit_out     (unit_code),
    .sig_sel_out  (sig_sel)
  );
  function automatic logic abit(input logic [23:0] w, input int n);
    abit = w[23 - n];
  endfunction

  // unit code is driven to peripherals continuously so their status
  // settles through the synchroniser before the test samples it
  assign unit_sel_out = unit_code;

  // ----------------------------------------------------------------
  // execution: wait for unit status to pass the synchroniser
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EVAL} ioac_st_t;
  ioac_st_t st_q, st_d;
  logic [1:0] wcnt_q, wcnt_d;
  logic       done_q, done_d, skip_q, skip_d;
  logic [14:0] npc_q, npc_d;
  logic       ien_q, ien_d, ovf_q, ovf_d;
  logic [23:0] ins_q, ins_d;
  logic       unit_skip, int_skip, sense_skip;
  logic [2:0] ev;

  always_comb begin
    // tape file protect is signal 5; same generic test applies
    unit_skip = |(sig_sel & ~usig);
    int_skip  = (abit(ins_q, `IOAC_BIT_YRDY) & yrdy)
              | (abit(ins_q, `IOAC_BIT_WRDY) & wrdy)
              | (|(ins_q[23-`IOAC_BIT_BKPT1 -: 4] & ~bkpt))
              | (abit(ins_q, `IOAC_BIT_YERR) & ~yerr)
              | (abit(ins_q, `IOAC_BIT_WERR) & ~werr)
              | (abit(ins_q, `IOAC_BIT_INT_OFF) & ien_q)
              | (abit(ins_q, `IOAC_BIT_INT_ON) & ~ien_q)
              | (abit(ins_q, `IOAC_BIT_OVF) & ~ovf_q);
    sense_skip = abit(ins_q, `IOAC_BIT_INTERNAL) ? int_skip : unit_skip;
  end

  always_comb begin
    st_d   = st_q;
    wcnt_d = wcnt_q;
    done_d = 1'b0;
    skip_d = skip_q;
    npc_d  = npc_q;
    ien_d  = ien_q;
    ovf_d  = ovf_q | ovf_set_in;
    ins_d  = ins_q;
    ev     = 3'b000;
    unique case (st_q)
      ST_IDLE: begin
        if (exec_in && cmd == IOAC_CMD_ENERGIZE) begin
          // unit control lives elsewhere; only internal set acts here
          if (internal) begin
            if (abit(instr_in, `IOAC_BIT_INT_OFF)) ien_d = 1'b0;
            if (abit(instr_in, `IOAC_BIT_INT_ON))  ien_d = 1'b1;
            // clear wins over a simultaneous overflow set
            if (abit(instr_in, `IOAC_BIT_OVF)) ovf_d = 1'b0;
          end
          skip_d = 1'b0;
          npc_d  = pc_in + 15'h0001;
          done_d = 1'b1;
          ev[0]  = 1'b1;
        end else if (exec_in && cmd == IOAC_CMD_SKIP) begin
          ins_d  = instr_in;
          wcnt_d = 2'h0;
          st_d   = ST_WAIT;
        end else if (exec_in) begin
          skip_d = 1'b0;
          npc_d  = pc_in + 15'h0001;
          done_d = 1'b1;
        end
      end
      ST_WAIT: begin
        wcnt_d = wcnt_q + 2'h1;
        if (wcnt_q == 2'h2) st_d = ST_EVAL;
      end
      ST_EVAL: begin
        skip_d = sense_skip;
        // a taken skip jumps one word further
        npc_d  = pc_in + (sense_skip ? 15'h0002 : 15'h0001);
        if (abit(ins_q, `IOAC_BIT_INTERNAL) &&
            abit(ins_q, `IOAC_BIT_OVF)) begin
          ovf_d = 1'b0;
        end
        done_d = 1'b1;
        ev[1]  = sense_skip;
        st_d   = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    ev[2] = ovf_set_in & ~ovf_q;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q   <= ST_IDLE;
      wcnt_q <= 2'h0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      npc_q  <= 15'h0000;
      ien_q  <= 1'b0;
      ovf_q  <= 1'b0;
      ins_q  <= 24'h00_0000;
    end else begin
      st_q   <= st_d;
      wcnt_q <= wcnt_d;
      done_q <= done_d;
      skip_q <= skip_d;
      npc_q  <= npc_d;
      ien_q  <= ien_d;
      ovf_q  <= ovf_d;
      ins_q  <= ins_d;
    end
  end

  assign done_out       = done_q;
  assign skip_out       = skip_q;
  assign next_pc_out    = npc_q;
  assign int_enable_out = ien_q;
  assign overflow_out   = ovf_q;

  // ----------------------------------------------------------------
  // apb registers and interrupt
  // ----------------------------------------------------------------
  logic [2:0]  ist_q, ist_d, msk_q, msk_d;
  logic [23:0] last_q, last_d;
  logic        wr;
  assign wr = psel & penable & pwrite;

  always_comb begin
    msk_d  = msk_q;
    // an exec during eval is refused, so only idle takes the live word
    last_d = done_d ? ((st_q == ST_IDLE) ? instr_in : ins_q) : last_q;
    ist_d  = ist_q;
    if (wr && paddr == `IOAC_OFF_IRQ_ST) ist_d = ist_q & ~pwdata[2:0];
    if (wr && paddr == `IOAC_OFF_IRQ_MSK) msk_d = pwdata[2:0];
    // set wins over a clear in the same cycle
    ist_d = ist_d | ev;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ist_q  <= 3'h0;
      msk_q  <= `IOAC_RST_MASK;
      last_q <= 24'h00_0000;
    end else begin
      ist_q  <= ist_d;
      msk_q  <= msk_d;
      last_q <= last_d;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `IOAC_OFF_CTRL:    prdata = {30'h0000_0000, ovf_q, ien_q};
      `IOAC_OFF_STATUS:  prdata = {16'h0000, 2'h0, usig, yrdy, wrdy, yerr,
                                   werr, bkpt};
      `IOAC_OFF_IRQ_ST:  prdata = {29'h0000_0000, ist_q};
      `IOAC_OFF_IRQ_MSK: prdata = {29'h0000_0000, msk_q};
      `IOAC_OFF_LAST:    prdata = {8'h00, last_q};
      default:           prdata = 32'h0000_0000;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr > `IOAC_OFF_LAST |
                                     paddr[1:0] != 2'h0);
  assign irq_out = |(ist_q & msk_q);
endmodule

// file: hdl/ioac_defs.svh
// constants for the i/o address condition decoder
`ifndef IOAC_DEFS_SVH
`define IOAC_DEFS_SVH

// ----------------------------------------------------------------
// opcodes (6-bit, octal 02 and 40)
// ----------------------------------------------------------------
`define IOAC_OP_ENERGIZE 6'h02
`define IOAC_OP_SKIP     6'h20

// ----------------------------------------------------------------
// address bit positions (instruction word bit 0 is msb of 24)
// ----------------------------------------------------------------
`define IOAC_BIT_INTERNAL  10
`define IOAC_BIT_SIG1      12
`define IOAC_BIT_YRDY      13
`define IOAC_BIT_WRDY      14
`define IOAC_BIT_BKPT1     15
`define IOAC_BIT_YERR      19
`define IOAC_BIT_WERR      20
`define IOAC_BIT_INT_OFF   21
`define IOAC_BIT_INT_ON    22
`define IOAC_BIT_OVF       23
`define IOAC_UNIT_LSB      18

// ----------------------------------------------------------------
// register offsets and resets
// ----------------------------------------------------------------
`define IOAC_OFF_CTRL    12'h000
`define IOAC_OFF_STATUS  12'h004
`define IOAC_OFF_IRQ_ST  12'h008
`define IOAC_OFF_IRQ_MSK 12'h00C
`define IOAC_OFF_LAST    12'h010
`define IOAC_RST_MASK    3'h0
`define IOAC_IRQ_W       3

`endif

// file: hdl/ioac_pkg.sv
// types for the i/o address condition decoder
package ioac_pkg;
  typedef enum logic [1:0] {
    IOAC_CMD_NONE,
    IOAC_CMD_ENERGIZE,
    IOAC_CMD_SKIP
  } ioac_cmd_t;
endpackage

// file: hdl/ioac_field_dec.sv
// field decoder: splits a 24-bit instruction into opcode classes
`timescale 1ns/1ps
`include "ioac_defs.svh"
module ioac_field_dec
  import ioac_pkg::*;
(
  input  wire logic [23:0] instr_in,
  output ioac_cmd_t        cmd_out,
  output logic             internal_out,
  output logic [5:0]       unit_out,
  output logic [5:0]       sig_sel_out
);
  logic [5:0] opcode;

  // word bit 0 is the msb, so bit n sits at vector index 23-n
  assign opcode = instr_in[20:15];

  always_comb begin
    unique case (opcode)
      `IOAC_OP_ENERGIZE: cmd_out = IOAC_CMD_ENERGIZE;
      `IOAC_OP_SKIP:     cmd_out = IOAC_CMD_SKIP;
      default:           cmd_out = IOAC_CMD_NONE;
    endcase
  end

  assign internal_out = instr_in[23 - `IOAC_BIT_INTERNAL];
  assign unit_out     = instr_in[23 - `IOAC_UNIT_LSB:0];
  // sig_sel_out[0] is signal 1 at word bit 12
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sel
      assign sig_sel_out[g] = instr_in[23 - `IOAC_BIT_SIG1 - g];
    end
  endgenerate
endmodule

// file: testbench/ioac_decoder_sva.sv
// assertion checker for the i/o address condition decoder
`timescale 1ns/1ps
module ioac_decoder_sva (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        exec_in,
  input wire logic [23:0] instr_in,
  input wire logic [14:0] pc_in,
  input wire logic        done_out,
  input wire logic        skip_out,
  input wire logic [14:0] next_pc_out,
  input wire logic [5:0]  unit_sel_out,
  input wire logic        int_enable_out,
  input wire logic        overflow_out,
  input wire logic        ovf_set_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic busy_q;
  logic busy_d;
  logic go;
  logic energize_output_instr;
  logic sks;
  // an exec during a running skip is refused, so it starts nothing
  assign go  = exec_in && (!busy_q || done_out);
  assign energize_output_instr = go && instr_in[20:15] == 6'h02;
  assign sks = go && instr_in[20:15] == 6'h20;
  always_comb begin
    busy_d = busy_q;
    if (sks) begin
      busy_d = 1'b1;
    end else if (done_out) begin
      busy_d = 1'b0;
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end
  // ---
  // properties
  // ---
  eom_done_a: assert property (energize_output_instr |=> done_out && !skip_out)
    else $error("energize did not finish as a plain step");
  sks_time_a: assert property (sks |=> !done_out [*4] ##1 done_out)
    else $error("skip finished at the wrong cycle");
  pc_step_a: assert property (done_out |->
    next_pc_out == pc_in + (skip_out ? 15'h2 : 15'h1))
    else $error("next pc does not follow the skip");
  int_on_a: assert property (energize_output_instr && instr_in[13] && instr_in[1]
    |=> int_enable_out) else $error("interrupt enable not set");
  int_off_a: assert property (energize_output_instr && instr_in[13]
    && instr_in[2:1] == 2'b10 |=> !int_enable_out)
    else $error("interrupt enable not cleared");
  ovf_off_a: assert property (energize_output_instr && instr_in[13] && instr_in[0]
    |=> !overflow_out) else $error("overflow not cleared by energize");
  sense_ovf_a: assert property (sks && instr_in[13] && instr_in[0]
    |-> ##6 (!overflow_out || $past(ovf_set_in)))
    else $error("overflow not cleared by sense");
  sense_ien_a: assert property (sks && instr_in[13:0] == 14'h2004
    |-> ##5 skip_out == int_enable_out)
    else $error("interrupt sense gave the wrong skip");
  unit_code_a: assert property (unit_sel_out == instr_in[5:0])
    else $error("unit code not passed out");
  cover property (sks && instr_in[13]);
  cover property (sks && !instr_in[13]);
  cover property (done_out && skip_out);
endmodule

// file: testbench/ioac_unit_model.sv
// far side: unit status lines looked up by unit code
`timescale 1ns/1ps
module ioac_unit_model (
  input  wire logic [5:0] unit_sel_in,
  output logic      [5:0] unit_sig_out
);
  // one status word per unit; tape units carry file protect on line 5
  logic [5:0] stat_q [64];
  assign unit_sig_out = stat_q[unit_sel_in];
endmodule

// file: testbench/test_io_address_condition_decoder.sv
// self-checking testbench for the i/o address condition decoder
`timescale 1ns/1ps
`include "ioac_defs.svh"
module test_io_address_condition_decoder;
  logic        clk_in, reset_in, exec_in, done_out, skip_out, ovf_set_in;
  logic [23:0] instr_in;
  logic [14:0] pc_in, next_pc_out;
  logic [5:0]  unit_sel_out, unit_sig_in;
  logic        ybuf_ready_in, wbuf_ready_in, ybuf_err_in, wbuf_err_in;
  logic [3:0]  bkpt_in;
  logic        int_enable_out, overflow_out, irq_out, ien_m, ovf_m, err;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, samples_checked, i;
  ioac_decoder dut (.*);
  ioac_unit_model partner (
    .unit_sel_in  (unit_sel_out),
    .unit_sig_out (unit_sig_in)
  );
  // ---
  // helpers
  // ---
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic exp_skip(logic [23:0] s);
    logic k;
    k = 1'b0;
    if (s[20:15] != `IOAC_OP_SKIP) return 1'b0;
    if (s[13]) begin
      k = (s[10] & ybuf_ready_in) | (s[9] & wbuf_ready_in)
        | (|(s[8:5] & ~bkpt_in)) | (s[4] & ~ybuf_err_in)
        | (s[3] & ~wbuf_err_in) | (s[2] & ien_m) | (s[1] & ~ien_m)
        | (s[0] & ~ovf_m);
    end else begin
      for (int j = 0; j < 6; j++) k |= s[11-j] & ~partner.stat_q[s[5:0]][j];
    end
    return k;
  endfunction
  // instruction held three cycles first so unit lines settle
  task automatic run(logic [5:0] op, logic [14:0] a);
    logic [14:0] pc;
    logic        e;
    logic [14:0] npc;
    pc = 15'($urandom);
    instr_in <= {3'b000, op, a};
    pc_in <= pc;
    repeat (3) @(posedge clk_in);
    e = exp_skip(instr_in);
    npc = pc + {14'h0000, e} + 15'h0001;
    exec_in <= 1'b1;
    @(posedge clk_in);
    exec_in <= 1'b0;
    do @(posedge clk_in); while (done_out !== 1'b1);
    check("skip", 32'(e), 32'(skip_out));
    check("next_pc", 32'(npc), 32'(next_pc_out));
    if (a[13] && op == `IOAC_OP_ENERGIZE) begin
      if (a[2]) ien_m = 1'b0;
      if (a[1]) ien_m = 1'b1;
    end
    if (a[13] && a[0] && (op == `IOAC_OP_ENERGIZE || op == `IOAC_OP_SKIP))
      ovf_m = 1'b0;
    @(posedge clk_in);
    check("int_enable", 32'(ien_m), 32'(int_enable_out));
    check("overflow", 32'(ovf_m), 32'(overflow_out));
  endtask
  task automatic scramble();
    {ybuf_ready_in, wbuf_ready_in, ybuf_err_in, wbuf_err_in} <= 4'($urandom);
    bkpt_in <= 4'($urandom);
    ovf_set_in <= 1'($urandom);
    @(posedge clk_in);
    ovf_m = ovf_m | ovf_set_in;
    ovf_set_in <= 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  initial begin
    {reset_in, exec_in, instr_in, pc_in, ovf_set_in} = {2'b10, 40'h0};
    {ybuf_ready_in, wbuf_ready_in, ybuf_err_in, wbuf_err_in} = 4'h0;
    {bkpt_in, psel, penable, pwrite, paddr, pwdata} = 51'h0;
    fail_count = 0;
    samples_checked = 0;
    ien_m = 1'b0;
    ovf_m = 1'b0;
    void'($urandom(76291));
    for (i = 0; i < 64; i++) partner.stat_q[i] = 6'($urandom);
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    run(`IOAC_OP_ENERGIZE, 15'h2000);
    check("irq_masked", 32'h0, 32'(irq_out));
    apb(1'b1, `IOAC_OFF_IRQ_MSK, 32'h0000_0001);
    @(posedge clk_in);
    check("irq_raised", 32'h1, 32'(irq_out));
    apb(1'b1, `IOAC_OFF_IRQ_ST, 32'h0000_0001);
    @(posedge clk_in);
    check("irq_cleared", 32'h0, 32'(irq_out));
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped_err", 32'h1, 32'(err));
    check("unmapped_rd", 32'h0, rd);
    run(`IOAC_OP_ENERGIZE, 15'h2002);
    run(`IOAC_OP_ENERGIZE, 15'h2004);
    run(`IOAC_OP_ENERGIZE, 15'h2006);
    run(`IOAC_OP_ENERGIZE, 15'h0102);
    // an opcode that is neither set nor sense only steps the pc
    run(6'h01, 15'h2007);
    scramble();
    run(`IOAC_OP_ENERGIZE, 15'h2001);
    apb(1'b0, `IOAC_OFF_CTRL, 32'h0);
    check("ctrl", {30'h0, ovf_m, ien_m}, rd);
    @(posedge clk_in);
    apb(1'b0, `IOAC_OFF_LAST, 32'h0);
    check("last_energize", 32'h0001_2001, rd);
    for (i = 0; i < 22; i++) begin
      scramble();
      run(`IOAC_OP_SKIP, 15'h2000 | (15'h0400 >> (i % 11)));
      if (i == 10) run(`IOAC_OP_ENERGIZE, 15'h2004);
    end
    partner.stat_q[6'h08] = 6'h3d;
    run(`IOAC_OP_SKIP, 15'h0408);
    partner.stat_q[6'h08] = 6'h02;
    run(`IOAC_OP_SKIP, 15'h0408);
    // the file protect test word: signal 5 of tape unit 1
    partner.stat_q[6'h08] = 6'h10;
    run(`IOAC_OP_SKIP, 15'h1088);
    partner.stat_q[6'h08] = 6'h2f;
    apb(1'b1, `IOAC_OFF_IRQ_ST, 32'h0000_0007);
    run(`IOAC_OP_SKIP, 15'h1088);
    apb(1'b0, `IOAC_OFF_IRQ_ST, 32'h0);
    check("irq_status", 32'h0000_0002, rd);
    @(posedge clk_in);
    apb(1'b0, `IOAC_OFF_LAST, 32'h0);
    check("last_skip", 32'h0010_1088, rd);
    @(posedge clk_in);
    apb(1'b0, `IOAC_OFF_STATUS, 32'h0);
    check("status", {18'h0, 6'h2f, ybuf_ready_in, wbuf_ready_in,
                     ybuf_err_in, wbuf_err_in, bkpt_in}, rd);
    for (i = 0; i < 40; i++) begin
      scramble();
      run(i[0] ? `IOAC_OP_SKIP : `IOAC_OP_ENERGIZE, 15'($urandom));
    end
    test_done();
  end
endmodule
bind ioac_decoder ioac_decoder_sva chk (.*);
